// ---- verilog/ccm_exec.v ----
// Executor for conditional compute, dual memory move, universal register
// move and index modify instructions of a two-element core.
// Assumes a decoded instruction per cycle and memories that return read
// data in the same cycle as the read strobe.
`timescale 1ns/10ps
`include "ccm_defines.vh"

module ccm_exec (
  input  wire        clk,
  input  wire        arst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_we,
  input  wire        reg_re,
  output reg  [31:0] reg_rdata,
  input  wire        ins_valid,
  input  wire [1:0]  ins_type,
  input  wire [1:0]  ins_size,
  input  wire [2:0]  ins_cond,
  input  wire [3:0]  ins_op,
  input  wire [3:0]  ins_rn,
  input  wire [3:0]  ins_rx,
  input  wire [2:0]  ins_ia,
  input  wire [2:0]  ins_mb,
  input  wire [2:0]  ins_ic,
  input  wire [2:0]  ins_md,
  input  wire        ins_dm_store,
  input  wire        ins_pm_store,
  input  wire [3:0]  ins_dm_reg,
  input  wire [3:0]  ins_pm_reg,
  input  wire [5:0]  ins_ureg,
  input  wire        ins_use_pm,
  input  wire        ins_premod,
  input  wire        ins_lw,
  input  wire        ins_mod_dest,
  input  wire        ins_mod_second_address_generator,
  input  wire [2:0]  ins_dest_idx,
  input  wire [31:0] dm_rdata_x,
  input  wire [31:0] dm_rdata_y,
  input  wire [31:0] pm_rdata_x,
  input  wire [31:0] pm_rdata_y,
  output reg  [31:0] dm_addr_x,
  output reg  [31:0] dm_addr_y,
  output reg  [31:0] dm_wdata_x,
  output reg  [31:0] dm_wdata_y,
  output reg         dm_re,
  output reg         dm_we,
  output reg         dm_y_en,
  output reg         dm_lw,
  output reg  [31:0] pm_addr_x,
  output reg  [31:0] pm_addr_y,
  output reg  [31:0] pm_wdata_x,
  output reg  [31:0] pm_wdata_y,
  output reg         pm_re,
  output reg         pm_we,
  output reg         pm_y_en,
  output reg         pm_lw,
  output reg         exec_x,
  output reg         exec_y
);

  function cond_ok;
    input [2:0] c;
    input       z;
    input       n;
    reg         t;
    begin
      case (c[1:0])
        `CCM_COND_EQ: t = z;
        `CCM_COND_LT: t = n;
        `CCM_COND_LE: t = z | n;
        default:      t = 1'b1;
      endcase
      cond_ok = t ^ c[2];
    end
  endfunction

  reg [31:0] idx_q [0:15];
  reg [31:0] mod_q [0:15];
  reg [31:0] rx_q  [0:15];
  reg [31:0] ry_q  [0:15];
  reg [3:0]  mode_q;
  reg        x_az_q, x_an_q, y_az_q, y_an_q;
  reg        ld_dm_q, ld_pm_q, ld_x_q, ld_y_q, ld_dbc_q, ld_pbc_q;
  reg [5:0]  ld_dm_reg_q, ld_pm_reg_q;
  integer    i;

  wire [31:0] res_x, res_y;
  wire        wr_x, wr_y, az_x, az_y, an_x, an_y;

  ccm_alu u_alu_x (
    .op  (ins_op),
    .a   (rx_q[ins_rn]),
    .b   (rx_q[ins_rx]),
    .res (res_x),
    .wr  (wr_x),
    .az  (az_x),
    .an  (an_x)
  );

  ccm_alu u_alu_y (
    .op  (ins_op),
    .a   (ry_q[ins_rn]),
    .b   (ry_q[ins_rx]),
    .res (res_y),
    .wr  (wr_y),
    .az  (az_y),
    .an  (an_y)
  );

  reg        has_cond, has_comp, simd, ex_x, ex_y, any_ex;
  reg        dual, umove, use_pm, u_store, dbc, pbc;
  reg [3:0]  di, dmi, pi, pmi, ui, umi;
  reg [31:0] k, kd, kp, ux, uy;

  always @* begin
    simd     = mode_q[`CCM_MODE_SIMD];
    dual     = (ins_type == `CCM_TYPE_DUAL);
    umove    = (ins_type == `CCM_TYPE_UREG);
    // Optional fields present per type and size suffix
    has_cond = (ins_type == `CCM_TYPE_MODIFY) ||
               (ins_type == `CCM_TYPE_COMP && ins_size == `CCM_SIZE_A) ||
               (umove && ins_size != `CCM_SIZE_C);
    has_comp = (ins_type == `CCM_TYPE_COMP) ||
               (ins_size == `CCM_SIZE_A && ins_type != `CCM_TYPE_MODIFY);
    ex_x     = ins_valid &&
               (!has_cond || cond_ok(ins_cond, x_az_q, x_an_q));
    ex_y     = ins_valid && simd &&
               (!has_cond || cond_ok(ins_cond, y_az_q, y_an_q));
    any_ex   = ex_x | ex_y;
    use_pm   = umove && ins_use_pm;
    u_store  = use_pm ? ins_pm_store : ins_dm_store;
    di       = {1'b0, ins_ia};
    dmi      = {1'b0, ins_mb};
    pi       = {1'b1, ins_ic};
    pmi      = {1'b1, ins_md};
    ui       = use_pm ? pi : di;
    umi      = use_pm ? pmi : dmi;
    k        = mode_q[`CCM_MODE_SHORT] && !ins_lw ?
               `CCM_K_SHORT : `CCM_K_NORMAL;
    dbc      = mode_q[`CCM_MODE_BROADCAST_READ_INDEX1] && di == `CCM_BCST_IDX_DM &&
               !(dual ? ins_dm_store : u_store);
    pbc      = mode_q[`CCM_MODE_BROADCAST_READ_INDEX9] && pi == `CCM_BCST_IDX_PM &&
               !(dual ? ins_pm_store : u_store);
    kd       = dbc ? `CCM_K_BCST : k;
    kp       = pbc ? `CCM_K_BCST : k;
    // Register named by a universal move, X and complementary Y value
    case (ins_ureg[5:4])
      `CCM_UGRP_DATA: begin
        ux = rx_q[ins_ureg[3:0]];
        uy = ry_q[ins_ureg[3:0]];
      end
      `CCM_UGRP_INDEX: begin
        ux = idx_q[ins_ureg[3:0]];
        uy = idx_q[ins_ureg[3:0]];
      end
      `CCM_UGRP_MODIFY: begin
        ux = mod_q[ins_ureg[3:0]];
        uy = mod_q[ins_ureg[3:0]];
      end
      default: begin
        ux = 32'h0;
        uy = 32'h0;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 16; i = i + 1) begin
        idx_q[i] <= 32'h0;
        mod_q[i] <= 32'h0;
        rx_q[i]  <= 32'h0;
        ry_q[i]  <= 32'h0;
      end
      mode_q <= `CCM_MODE_RESET;
      {x_az_q, x_an_q, y_az_q, y_an_q} <= 4'h0;
      {ld_dm_q, ld_pm_q, ld_x_q, ld_y_q, ld_dbc_q, ld_pbc_q} <= 6'h0;
      ld_dm_reg_q <= 6'h0;
      ld_pm_reg_q <= 6'h0;
      reg_rdata   <= 32'h0;
      {dm_addr_x, dm_addr_y, dm_wdata_x, dm_wdata_y} <= 128'h0;
      {pm_addr_x, pm_addr_y, pm_wdata_x, pm_wdata_y} <= 128'h0;
      {dm_re, dm_we, dm_y_en, dm_lw} <= 4'h0;
      {pm_re, pm_we, pm_y_en, pm_lw} <= 4'h0;
      exec_x <= 1'b0;
      exec_y <= 1'b0;
    end else begin
      // Read port: data valid in the cycle after the strobe only
      reg_rdata <= 32'h0;
      if (reg_re) begin
        case (reg_addr[7:4])
          `CCM_GRP_CTRL:
            if (reg_addr == `CCM_ADDR_MODE)
              reg_rdata <= {28'h0, mode_q};
            else if (reg_addr == `CCM_ADDR_STATUS)
              reg_rdata <= {26'h0, exec_y, exec_x,
                            y_an_q, y_az_q, x_an_q, x_az_q};
          `CCM_GRP_INDEX:  reg_rdata <= idx_q[reg_addr[3:0]];
          `CCM_GRP_MODIFY: reg_rdata <= mod_q[reg_addr[3:0]];
          `CCM_GRP_RX:     reg_rdata <= rx_q[reg_addr[3:0]];
          `CCM_GRP_RY:     reg_rdata <= ry_q[reg_addr[3:0]];
          default:         reg_rdata <= 32'h0;
        endcase
      end
      if (reg_we) begin
        case (reg_addr[7:4])
          `CCM_GRP_CTRL:
            if (reg_addr == `CCM_ADDR_MODE)
              mode_q <= reg_wdata[3:0];
          `CCM_GRP_INDEX:  idx_q[reg_addr[3:0]] <= reg_wdata;
          `CCM_GRP_MODIFY: mod_q[reg_addr[3:0]] <= reg_wdata;
          `CCM_GRP_RX:     rx_q[reg_addr[3:0]]  <= reg_wdata;
          `CCM_GRP_RY:     ry_q[reg_addr[3:0]]  <= reg_wdata;
          default: ;
        endcase
      end
      // Load write-back of data returned in the strobe cycle
      if (ld_dm_q && ld_x_q)
        case (ld_dm_reg_q[5:4])
          `CCM_UGRP_INDEX:  idx_q[ld_dm_reg_q[3:0]] <= dm_rdata_x;
          `CCM_UGRP_MODIFY: mod_q[ld_dm_reg_q[3:0]] <= dm_rdata_x;
          default:          rx_q[ld_dm_reg_q[3:0]]  <= dm_rdata_x;
        endcase
      if (ld_dm_q && ld_y_q && ld_dm_reg_q[5:4] == `CCM_UGRP_DATA)
        ry_q[ld_dm_reg_q[3:0]] <= ld_dbc_q ? dm_rdata_x : dm_rdata_y;
      if (ld_pm_q && ld_x_q)
        case (ld_pm_reg_q[5:4])
          `CCM_UGRP_INDEX:  idx_q[ld_pm_reg_q[3:0]] <= pm_rdata_x;
          `CCM_UGRP_MODIFY: mod_q[ld_pm_reg_q[3:0]] <= pm_rdata_x;
          default:          rx_q[ld_pm_reg_q[3:0]]  <= pm_rdata_x;
        endcase
      if (ld_pm_q && ld_y_q && ld_pm_reg_q[5:4] == `CCM_UGRP_DATA)
        ry_q[ld_pm_reg_q[3:0]] <= ld_pbc_q ? pm_rdata_x : pm_rdata_y;
      // Execute stage
      {dm_re, dm_we, pm_re, pm_we} <= 4'h0;
      ld_dm_q  <= 1'b0;
      ld_pm_q  <= 1'b0;
      exec_x   <= ex_x;
      exec_y   <= ex_y;
      ld_x_q   <= ex_x;
      ld_y_q   <= ex_y;
      ld_dbc_q <= dbc;
      ld_pbc_q <= pbc;
      dm_y_en  <= ex_y;
      pm_y_en  <= ex_y;
      if (any_ex && dual) begin
        dm_addr_x  <= idx_q[di];
        dm_addr_y  <= idx_q[di] + kd;
        pm_addr_x  <= idx_q[pi];
        pm_addr_y  <= idx_q[pi] + kp;
        dm_wdata_x <= rx_q[ins_dm_reg];
        dm_wdata_y <= ry_q[ins_dm_reg];
        pm_wdata_x <= rx_q[ins_pm_reg];
        pm_wdata_y <= ry_q[ins_pm_reg];
        dm_we      <= ins_dm_store;
        dm_re      <= !ins_dm_store;
        pm_we      <= ins_pm_store;
        pm_re      <= !ins_pm_store;
        dm_lw      <= 1'b0;
        pm_lw      <= 1'b0;
        ld_dm_q    <= !ins_dm_store;
        ld_pm_q    <= !ins_pm_store;
        ld_dm_reg_q <= {`CCM_UGRP_DATA, ins_dm_reg};
        ld_pm_reg_q <= {`CCM_UGRP_DATA, ins_pm_reg};
        idx_q[di]  <= idx_q[di] + mod_q[dmi];
        idx_q[pi]  <= idx_q[pi] + mod_q[pmi];
      end
      if (any_ex && umove) begin
        // ureg never shares the generator of ui/umi
        if (use_pm) begin
          pm_addr_x  <= ins_premod ? idx_q[ui] + mod_q[umi] : idx_q[ui];
          pm_addr_y  <= ins_premod ? idx_q[ui] + kp + mod_q[umi]
                                   : idx_q[ui] + kp;
          pm_wdata_x <= ux;
          pm_wdata_y <= uy;
          pm_we      <= u_store;
          pm_re      <= !u_store;
          pm_lw      <= ins_lw;
          ld_pm_q    <= !u_store;
          ld_pm_reg_q <= ins_ureg;
        end else begin
          dm_addr_x  <= ins_premod ? idx_q[ui] + mod_q[umi] : idx_q[ui];
          dm_addr_y  <= ins_premod ? idx_q[ui] + kd + mod_q[umi]
                                   : idx_q[ui] + kd;
          dm_wdata_x <= ux;
          dm_wdata_y <= uy;
          dm_we      <= u_store;
          dm_re      <= !u_store;
          dm_lw      <= ins_lw;
          ld_dm_q    <= !u_store;
          ld_dm_reg_q <= ins_ureg;
        end
        if (!ins_premod)
          idx_q[ui] <= idx_q[ui] + mod_q[umi];
      end
      if (any_ex && ins_type == `CCM_TYPE_MODIFY) begin
        if (ins_mod_dest)
          idx_q[{ins_mod_second_address_generator, ins_dest_idx}] <= ins_mod_second_address_generator ?
            idx_q[pi] + mod_q[pmi] : idx_q[di] + mod_q[dmi];
        else if (ins_mod_second_address_generator)
          idx_q[pi] <= idx_q[pi] + mod_q[pmi];
        else
          idx_q[di] <= idx_q[di] + mod_q[dmi];
      end
      // Compute runs beside the transfer, same instruction
      if (has_comp && ex_x) begin
        if (wr_x)
          rx_q[ins_rn] <= res_x;
        x_az_q <= az_x;
        x_an_q <= an_x;
      end
      if (has_comp && ex_y) begin
        if (wr_y)
          ry_q[ins_rn] <= res_y;
        y_az_q <= az_y;
        y_an_q <= an_y;
      end
    end
  end

endmodule // ccm_exec

// ---- common/ccm_defines.vh ----
// Constants for the conditional compute and memory move executor.
// Included by the executor and its compute unit; definitions only.
`ifndef CCM_DEFINES_VH
`define CCM_DEFINES_VH

// Instruction type codes
`define CCM_TYPE_DUAL    2'h0
`define CCM_TYPE_COMP    2'h1
`define CCM_TYPE_UREG    2'h2
`define CCM_TYPE_MODIFY  2'h3
// Size suffix codes: a = 48 bit, b = 32 bit, c = 16 bit
`define CCM_SIZE_A       2'h0
`define CCM_SIZE_B       2'h1
`define CCM_SIZE_C       2'h2
// Compute operation codes
`define CCM_OP_ADD       4'h0
`define CCM_OP_SUB       4'h1
`define CCM_OP_PASS      4'h2
`define CCM_OP_NOT       4'h3
`define CCM_OP_AND       4'h4
`define CCM_OP_OR        4'h5
`define CCM_OP_XOR       4'h6
`define CCM_OP_INC       4'h7
`define CCM_OP_DEC       4'h8
`define CCM_OP_COMP      4'h9
`define CCM_OP_MUL       4'hA
`define CCM_OP_FADD      4'hB
`define CCM_OP_FSUB      4'hC
`define CCM_OP_FMUL      4'hD
`define CCM_OP_FCOMP     4'hE
`define CCM_OP_FLOAT     4'hF
// Condition codes, bit 2 negates
`define CCM_COND_EQ      2'h0
`define CCM_COND_LT      2'h1
`define CCM_COND_LE      2'h2
`define CCM_COND_TRUE    2'h3
// Universal register groups, bits 5:4 of the register code
`define CCM_UGRP_DATA    2'h0
`define CCM_UGRP_INDEX   2'h1
`define CCM_UGRP_MODIFY  2'h2
// Core mode register bits
`define CCM_MODE_SIMD    0
`define CCM_MODE_BROADCAST_READ_INDEX1   1
`define CCM_MODE_BROADCAST_READ_INDEX9   2
`define CCM_MODE_SHORT   3
`define CCM_MODE_RESET   4'h0
// Y element implicit offsets
`define CCM_K_NORMAL     32'h00000001
`define CCM_K_SHORT      32'h00000002
`define CCM_K_BCST       32'h00000000
// Broadcast index registers
`define CCM_BCST_IDX_DM  4'h1
`define CCM_BCST_IDX_PM  4'h9
// Register port map, upper nibble selects the group
`define CCM_ADDR_MODE    8'h00
`define CCM_ADDR_STATUS  8'h01
`define CCM_GRP_CTRL     4'h0
`define CCM_GRP_INDEX    4'h1
`define CCM_GRP_MODIFY   4'h2
`define CCM_GRP_RX       4'h4
`define CCM_GRP_RY       4'h5

`endif

// ---- verilog/ccm_alu.v ----
// Short compute unit: fixed and floating point operations of one element.
// Purely combinational; the executor registers the result.
`timescale 1ns/10ps
`include "ccm_defines.vh"

module ccm_alu (
  input  wire [3:0]  op,
  input  wire [31:0] a,
  input  wire [31:0] b,
  output reg  [31:0] res,
  output reg         wr,
  output reg         az,
  output reg         an
);

  // Single precision add, truncating, denormal inputs taken with a zero hidden bit
  function [31:0] f_add;
    input [31:0] x;
    input [31:0] y;
    reg [31:0] t;
    reg [24:0] mx, my, sm;
    reg [7:0]  e;
    integer    d, i;
    begin
      if (x[30:0] < y[30:0]) begin
        t = x;
        x = y;
        y = t;
      end
      mx = {1'b0, |x[30:23], x[22:0]};
      my = {1'b0, |y[30:23], y[22:0]};
      d  = x[30:23] - y[30:23];
      my = (d > 24) ? 25'h0 : (my >> d);
      sm = (x[31] == y[31]) ? mx + my : mx - my;
      e  = x[30:23];
      if (sm[24]) begin
        sm = sm >> 1;
        e  = e + 8'h01;
      end
      for (i = 0; i < 24; i = i + 1)
        if (!sm[23] && sm != 25'h0) begin
          sm = sm << 1;
          e  = e - 8'h01;
        end
      f_add = (sm == 25'h0) ? 32'h00000000 : {x[31], e, sm[22:0]};
    end
  endfunction

  function [31:0] f_mul;
    input [31:0] x;
    input [31:0] y;
    reg [47:0] p;
    reg [9:0]  e;
    reg [22:0] m;
    begin
      p = {24'h0, 1'b1, x[22:0]} * {24'h0, 1'b1, y[22:0]};
      e = {2'b00, x[30:23]} + {2'b00, y[30:23]} - 10'h07F;
      if (p[47]) begin
        e = e + 10'h001;
        m = p[46:24];
      end else
        m = p[45:23];
      if (x[30:23] == 8'h00 || y[30:23] == 8'h00 || e[9] || e == 10'h0)
        f_mul = 32'h00000000;
      else if (e >= 10'h0FF)
        f_mul = {x[31] ^ y[31], 8'hFF, 23'h0};
      else
        f_mul = {x[31] ^ y[31], e[7:0], m};
    end
  endfunction

  function [31:0] f_float;
    input [31:0] x;
    reg [31:0] mag;
    reg [7:0]  pos;
    integer    i;
    begin
      mag = x[31] ? (~x + 32'h00000001) : x;
      pos = 8'h00;
      for (i = 0; i < 32; i = i + 1)
        if (mag[i])
          pos = i[7:0];
      mag = mag << (8'h1F - pos);
      f_float = (x == 32'h0) ? 32'h0 :
                {x[31], pos + 8'h7F, mag[30:8]};
    end
  endfunction

  function f_less;
    input [31:0] x;
    input [31:0] y;
    begin
      if (x[31] != y[31])
        f_less = x[31] && (x[30:0] != 31'h0 || y[30:0] != 31'h0);
      else if (x[31])
        f_less = x[30:0] > y[30:0];
      else
        f_less = x[30:0] < y[30:0];
    end
  endfunction

  reg [63:0] prod;

  always @* begin
    prod = $signed(a) * $signed(b);
    wr   = 1'b1;
    case (op)
      `CCM_OP_ADD:   res = a + b;
      `CCM_OP_SUB:   res = a - b;
      `CCM_OP_PASS:  res = b;
      `CCM_OP_NOT:   res = ~b;
      `CCM_OP_AND:   res = a & b;
      `CCM_OP_OR:    res = a | b;
      `CCM_OP_XOR:   res = a ^ b;
      `CCM_OP_INC:   res = b + 32'h00000001;
      `CCM_OP_DEC:   res = b - 32'h00000001;
      `CCM_OP_MUL:   res = prod[31:0];
      `CCM_OP_FADD:  res = f_add(a, b);
      `CCM_OP_FSUB:  res = f_add(a, {~b[31], b[30:0]});
      `CCM_OP_FMUL:  res = f_mul(a, b);
      `CCM_OP_FLOAT: res = f_float(b);
      default:       res = a;
    endcase
    if (op == `CCM_OP_COMP) begin
      wr = 1'b0;
      az = (a == b);
      an = $signed(a) < $signed(b);
    end else if (op == `CCM_OP_FCOMP) begin
      wr = 1'b0;
      az = (a[30:0] == 31'h0 && b[30:0] == 31'h0) || a == b;
      an = f_less(a, b);
    end else begin
      az = (res == 32'h0);
      an = res[31];
    end
  end

endmodule // ccm_alu

// ---- test/ccm_exec_checker.sv ----
// Checker for the conditional compute and memory move executor.
// Sees only the executor's ports; bound to every executor instance.
`timescale 1ns/10ps

module ccm_exec_checker (
  input wire        clk,
  input wire        arst_n,
  input wire        reg_re,
  input wire [31:0] reg_rdata,
  input wire        ins_valid,
  input wire [1:0]  ins_type,
  input wire [1:0]  ins_size,
  input wire [2:0]  ins_cond,
  input wire [3:0]  ins_op,
  input wire [31:0] dm_addr_x,
  input wire [31:0] dm_addr_y,
  input wire        dm_re,
  input wire        dm_we,
  input wire        dm_y_en,
  input wire        dm_lw,
  input wire        pm_re,
  input wire        pm_we,
  input wire        exec_x,
  input wire        exec_y
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_dual;
    ins_valid && ins_type == 2'h0;
  endsequence
  sequence s_false;
    ins_valid && ins_cond == 3'h7 &&
      (ins_type == 2'h3 || (ins_type == 2'h1 && ins_size == 2'h0));
  endsequence
  sequence s_none;
    !dm_re && !dm_we && !pm_re && !pm_we && !exec_x && !exec_y;
  endsequence

  property p_rd_zero;
    !reg_re |=> reg_rdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data not zero outside read slot");
  property p_false;
    s_false |=> s_none;
  endproperty
  a_false: assert property (p_false)
    else $error("false condition still acted");
  property p_quiet;
    !ins_valid |=> s_none;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("activity without an instruction");
  property p_nocond;
    s_dual |=> exec_x;
  endproperty
  a_nocond: assert property (p_nocond)
    else $error("unconditional dual move not executed");
  property p_dual;
    s_dual |=> (dm_re || dm_we) && (pm_re || pm_we) && !dm_lw;
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual move missed a memory");
  property p_short;
    ins_valid && ins_type == 2'h1 && ins_size == 2'h2 |=> exec_x;
  endproperty
  a_short: assert property (p_short)
    else $error("short compute not executed");
  property p_yoff;
    (dm_re || dm_we) && dm_y_en |-> dm_addr_y - dm_addr_x <= 32'h2;
  endproperty
  a_yoff: assert property (p_yoff)
    else $error("Y lane offset out of range");
  property p_lw;
    (dm_re || dm_we) && dm_y_en && dm_lw |-> dm_addr_y - dm_addr_x <= 32'h1;
  endproperty
  a_lw: assert property (p_lw)
    else $error("long word offset wrong");
  property p_par;
    ins_valid && ins_type == 2'h2 && ins_size == 2'h0 && ins_cond == 3'h3
      |=> exec_x && (dm_re || dm_we || pm_re || pm_we);
  endproperty
  a_par: assert property (p_par)
    else $error("compute and move not together");
endmodule // ccm_exec_checker

bind ccm_exec ccm_exec_checker u_chk (.*);

// ---- test/ccm_mem_model.sv ----
// Behavioural memory with an X and a Y lane, read data in the strobe cycle.
// Outside a read the data lines toggle so a stale word never looks valid in the cycle after the read.
`timescale 1ns/10ps

module ccm_mem_model #(
  parameter [31:0] BASE = 32'h0
) (
  input  wire        clk,
  input  wire [31:0] addr_x,
  input  wire [31:0] addr_y,
  input  wire [31:0] wdata_x,
  input  wire [31:0] wdata_y,
  input  wire        re,
  input  wire        we,
  input  wire        y_en,
  output wire [31:0] rdata_x,
  output wire [31:0] rdata_y
);
  logic [31:0] mem [256];
  logic [31:0] idle_x = 32'h0;
  logic [31:0] idle_y = 32'h0;

  initial begin
    for (int n = 0; n < 256; n++)
      mem[n] = BASE + n;
  end
  assign rdata_x = re ? mem[addr_x[7:0]] : idle_x;
  assign rdata_y = re ? mem[addr_y[7:0]] : idle_y;
  always @(posedge clk) begin
    idle_x <= ~rdata_x;
    idle_y <= ~rdata_y;
    if (we) begin
      mem[addr_x[7:0]] <= wdata_x;
      if (y_en)
        mem[addr_y[7:0]] <= wdata_y;
    end
  end
endmodule // ccm_mem_model

// ---- test/cond_compute_move_exec_tb.sv ----
// Self-checking bench for the executor with data and program memory models.
// Registers are reached over the plain register port.
`timescale 1ns/10ps

module cond_compute_move_exec_tb;
  typedef struct packed {
    logic [3:0]  op;
    logic [7:0]  ra;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] e;
  } ccm_row_t;
  logic        clk = 0, arst_n = 0;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic        reg_we = 0, reg_re = 0, ins_valid = 0;
  logic [1:0]  ins_type = 0, ins_size = 0;
  logic [2:0]  ins_cond = 0, ins_ia = 0, ins_mb = 0, ins_ic = 0;
  logic [2:0]  ins_md = 0, ins_dest_idx = 0;
  logic [3:0]  ins_op = 0, ins_rn = 0, ins_rx = 0;
  logic [3:0]  ins_dm_reg = 0, ins_pm_reg = 0;
  logic [5:0]  ins_ureg = 0;
  logic        ins_dm_store = 0, ins_pm_store = 0, ins_use_pm = 0;
  logic        ins_premod = 0, ins_lw = 0, ins_mod_dest = 0;
  logic        ins_mod_second_address_generator = 0;
  wire  [31:0] reg_rdata, dm_rdata_x, dm_rdata_y, pm_rdata_x, pm_rdata_y;
  wire  [31:0] dm_addr_x, dm_addr_y, dm_wdata_x, dm_wdata_y;
  wire  [31:0] pm_addr_x, pm_addr_y, pm_wdata_x, pm_wdata_y;
  wire         dm_re, dm_we, dm_y_en, dm_lw, pm_re, pm_we, pm_y_en, pm_lw;
  wire         exec_x, exec_y;
  int          fails = 0, checks = 0, cyc = 0, i;
  logic [4:0]  ex;
  logic [3:0]  mode_t [4] = '{4'h1, 4'h9, 4'h3, 4'h5};
  logic [31:0] kd_t [4] = '{32'h1, 32'h2, 32'h0, 32'h1};
  logic [31:0] kp_t [4] = '{32'h1, 32'h2, 32'h1, 32'h0};
  ccm_row_t    rows [16] = '{
    '{4'h0, 8'h41, 32'hC, 32'hA, 32'h16},
    '{4'h1, 8'h41, 32'hC, 32'hA, 32'h2},
    '{4'h2, 8'h41, 32'hC, 32'hA, 32'hA},
    '{4'h3, 8'h41, 32'hC, 32'hA, 32'hFFFFFFF5},
    '{4'h4, 8'h41, 32'hC, 32'hA, 32'h8},
    '{4'h5, 8'h41, 32'hC, 32'hA, 32'hE},
    '{4'h6, 8'h41, 32'hC, 32'hA, 32'h6},
    '{4'h7, 8'h41, 32'hC, 32'hA, 32'hB},
    '{4'h8, 8'h41, 32'hC, 32'hA, 32'h9},
    '{4'h9, 8'h01, 32'h5, 32'h5, 32'h1},
    '{4'hA, 8'h41, 32'hC, 32'hA, 32'h78},
    '{4'hB, 8'h41, 32'h3F800000, 32'h3F800000, 32'h40000000},
    '{4'hC, 8'h41, 32'h40400000, 32'h3F800000, 32'h40000000},
    '{4'hD, 8'h41, 32'h40000000, 32'h3FC00000, 32'h40400000},
    '{4'hE, 8'h01, 32'h3F800000, 32'h40000000, 32'h2},
    '{4'hF, 8'h41, 32'h0, 32'h3, 32'h40400000}};

  ccm_exec uut (.*);
  ccm_mem_model #(.BASE(32'hA0000000)) u_dm (.clk(clk),
    .addr_x(dm_addr_x), .addr_y(dm_addr_y), .wdata_x(dm_wdata_x),
    .wdata_y(dm_wdata_y), .re(dm_re), .we(dm_we), .y_en(dm_y_en),
    .rdata_x(dm_rdata_x), .rdata_y(dm_rdata_y));
  ccm_mem_model #(.BASE(32'hB0000000)) u_pm (.clk(clk),
    .addr_x(pm_addr_x), .addr_y(pm_addr_y), .wdata_x(pm_wdata_x),
    .wdata_y(pm_wdata_y), .re(pm_re), .we(pm_we), .y_en(pm_y_en),
    .rdata_x(pm_rdata_x), .rdata_y(pm_rdata_y));

  task chk(input [31:0] v, input [31:0] e);
    checks++;
    if (v !== e) begin
      fails++;
      $display("MISMATCH %0t %h %h", $time, v, e);
    end
  endtask
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    reg_we <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clk);
    reg_re <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 0;
    @(negedge clk);
    chk(reg_rdata, e);
    @(posedge clk);
  endtask
  // Issues one instruction, then leaves room for a load write-back
  task ins(input [1:0] t, input [1:0] s, input [2:0] c, input [3:0] op);
    @(posedge clk);
    ins_valid <= 1;
    ins_type <= t;
    ins_size <= s;
    ins_cond <= c;
    ins_op <= op;
    @(posedge clk);
    ins_valid <= 0;
    @(negedge clk);
    ex = {pm_lw, pm_y_en, dm_lw, exec_y, exec_x};
    repeat (2) @(posedge clk);
  endtask

  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      results;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1;
    rd(8'h00, 32'h0);
    wr(8'h80, 32'hFFFF);
    rd(8'h80, 32'h0);
    ins_rn <= 4'h1;
    ins_rx <= 4'h2;
    for (i = 0; i < 16; i++) begin
      wr(8'h41, rows[i].a);
      wr(8'h42, rows[i].b);
      ins(2'h1, 2'h2, 3'h7, rows[i].op);
      rd(rows[i].ra, rows[i].e);
    end
    wr(8'h41, 32'h7);
    ins_rx <= 4'h1;
    ins(2'h1, 2'h0, 3'h7, 4'h7);
    chk({27'h0, ex}, 32'h0);
    rd(8'h41, 32'h7);
    ins(2'h1, 2'h0, 3'h3, 4'h7);
    rd(8'h41, 32'h8);
    ins(2'h1, 2'h1, 3'h7, 4'h7);
    rd(8'h41, 32'h9);
    wr(8'h00, 32'h1);
    wr(8'h41, 32'h1);
    wr(8'h42, 32'h1);
    wr(8'h51, 32'h1);
    wr(8'h52, 32'h2);
    ins_rx <= 4'h2;
    ins(2'h1, 2'h0, 3'h3, 4'h9);
    ins(2'h1, 2'h0, 3'h0, 4'h0);
    chk({27'h0, ex}, 32'h1);
    rd(8'h41, 32'h2);
    rd(8'h51, 32'h1);
    ins_ia <= 3'h1;
    ins_mb <= 3'h2;
    ins_ic <= 3'h1;
    ins_md <= 3'h1;
    ins_dm_reg <= 4'h3;
    ins_pm_reg <= 4'h4;
    wr(8'h22, 32'h3);
    wr(8'h29, 32'h5);
    for (i = 0; i < 4; i++) begin
      wr(8'h00, {28'h0, mode_t[i]});
      wr(8'h11, 32'h10);
      wr(8'h19, 32'h20);
      ins(2'h0, 2'h1, 3'h7, 4'h0);
      chk(dm_addr_x, 32'h10);
      chk(dm_addr_y, 32'h10 + kd_t[i]);
      chk(pm_addr_x, 32'h20);
      chk(pm_addr_y, 32'h20 + kp_t[i]);
      rd(8'h11, 32'h13);
      rd(8'h19, 32'h25);
      rd(8'h43, 32'hA0000010);
      rd(8'h53, 32'hA0000010 + kd_t[i]);
      rd(8'h44, 32'hB0000020);
      rd(8'h54, 32'hB0000020 + kp_t[i]);
    end
    wr(8'h00, 32'h0);
    wr(8'h11, 32'h10);
    wr(8'h45, 32'h55);
    ins_ureg <= 6'h05;
    ins_dm_store <= 1;
    ins_premod <= 1;
    ins(2'h2, 2'h2, 3'h7, 4'h0);
    chk(dm_addr_x, 32'h13);
    chk(dm_wdata_x, 32'h55);
    rd(8'h11, 32'h10);
    ins_premod <= 0;
    ins(2'h2, 2'h2, 3'h7, 4'h0);
    chk(dm_addr_x, 32'h10);
    rd(8'h11, 32'h13);
    wr(8'h00, 32'h9);
    wr(8'h47, 32'h2);
    ins_ureg <= 6'h06;
    ins_dm_store <= 0;
    ins_lw <= 1;
    ins_rn <= 4'h7;
    ins_rx <= 4'h7;
    ins(2'h2, 2'h0, 3'h3, 4'h0);
    ins_lw <= 0;
    chk({27'h0, ex}, 32'hF);
    chk(dm_addr_y, 32'h14);
    rd(8'h46, 32'h55);
    rd(8'h56, 32'hA0000014);
    rd(8'h47, 32'h4);
    // SIMD dual store: both lanes of both memories carry R and S data
    ins_dm_store <= 1;
    ins_pm_store <= 1;
    ins_pm_reg <= 4'h6;
    ins(2'h0, 2'h1, 3'h7, 4'h0);
    chk({27'h0, ex}, 32'hB);
    chk(dm_wdata_x, 32'hA0000010);
    chk(dm_wdata_y, 32'hA0000011);
    chk(pm_wdata_x, 32'h55);
    chk(pm_wdata_y, 32'hA0000014);
    chk(pm_addr_y, 32'h27);
    wr(8'h11, 32'h10);
    ins_mod_dest <= 1;
    ins_dest_idx <= 3'h3;
    ins(2'h3, 2'h1, 3'h3, 4'h0);
    rd(8'h13, 32'h13);
    ins_mod_dest <= 0;
    ins(2'h3, 2'h1, 3'h7, 4'h0);
    rd(8'h11, 32'h10);
    ins(2'h3, 2'h1, 3'h3, 4'h0);
    rd(8'h11, 32'h13);
    // Reset in mid-run clears index and mode registers
    arst_n <= 0;
    repeat (2) @(posedge clk);
    arst_n <= 1;
    rd(8'h13, 32'h0);
    rd(8'h00, 32'h0);
    results;
  end
endmodule // cond_compute_move_exec_tb
